/* inc/pdm_params.svh */
/*
 * Register addresses, field positions and reset values of the port logic.
 * Assumes a 7-bit data-memory address with a 2-bit bank select, and a
 * separate register-file address space.
 */
`ifndef PDM_PARAMS_SVH
`define PDM_PARAMS_SVH

`define PDM_RF_DIR_A 7'h37
`define PDM_RF_DIR_B 7'h36
`define PDM_RF_DIR_C 7'h35
`define PDM_RF_DIR_G 7'h27
`define PDM_DM_PORT_A 7'h70
`define PDM_DM_PORT_B 7'h71
`define PDM_DM_PORT_G 7'h72
`define PDM_DM_PORT_C 7'h70
`define PDM_DM_SEG_E 7'h6b
`define PDM_DM_SEG_F 7'h6d
`define PDM_DM_HOLE_LO 7'h70
`define PDM_DM_HOLE_HI 7'h73
`define PDM_BANK0 2'h0
`define PDM_BANK1 2'h1
`define PDM_BANK2 2'h2
`define PDM_BANK3 2'h3
`define PDM_GROUP_DIR_BIT 0
`define PDM_DIR_RESET 4'h0
`define PDM_DATA_RESET 4'h0

`endif

/* inc/pdm_pkg.sv */
/*
 * Types shared by the port logic.
 * Assumes the header of constants is compiled alongside.
 */
package pdm_pkg;

    typedef logic [3:0] pdm_nib_type;

    typedef struct packed {
        logic [1:0] bank;
        logic [6:0] addr;
        logic wr;
        logic rd;
        logic [3:0] wdata;
    } pdm_dm_req_type;

    typedef struct packed {
        logic [6:0] addr;
        logic wr;
        logic rd;
        logic [3:0] wdata;
    } pdm_rf_req_type;

    typedef struct packed {
        logic hit;
        logic [3:0] rdata;
    } pdm_rsp_type;

    typedef struct packed {
        pdm_nib_type out;
        pdm_nib_type oe;
    } pdm_pin_drive_type;

    typedef enum logic [2:0] {
        PDM_SEL_NONE,
        PDM_SEL_A,
        PDM_SEL_B,
        PDM_SEL_C,
        PDM_SEL_G
    } pdm_sel_type;

endpackage : pdm_pkg

/* rtl/pdm_nibble_store.sv */
/*
 * Small register file of 4-bit words with a registered read port.
 * Assumes one synchronous writer and one reader in the clk_sys domain.
 */
module pdm_nibble_store
    import pdm_pkg::*;
#(
    parameter int DEPTH = 6
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [3:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [3:0] rd_data,
    output logic [DEPTH*4-1:0] all_q
);

    typedef struct packed {
        logic [DEPTH*4-1:0] mem;
        logic [3:0] rd;
    } pdm_store_state_type;

    pdm_store_state_type s_q;
    pdm_store_state_type s_d;

    if (DEPTH < 2) begin : g_depth_check
        $error("pdm_nibble_store needs at least two words");
    end

    always_comb begin
        s_d = s_q;
        if (wr_en && int'(wr_idx) < DEPTH) begin
            s_d.mem[wr_idx*4 +: 4] = wr_data;
        end
        s_d.rd = (int'(rd_idx) < DEPTH) ? s_q.mem[rd_idx*4 +: 4] : 4'h0;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd;
    assign all_q = s_q.mem;

endmodule : pdm_nibble_store

/* rtl/pdm_port_map.sv */
/*
 * Direction and data logic of the bidirectional ports and the
 * segment-shared output ports.
 * Assumes CPU requests synchronous to clk_sys, one per cycle; rst is the
 * merged power-on, clock-stop and chip-enable reset. Read data appear one
 * cycle after the read strobe.
 */
`include "pdm_params.svh"

module pdm_port_map
    import pdm_pkg::*;
#(
    parameter bit HAS_BANK3 = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire pdm_dm_req_type dm_req,
    output pdm_rsp_type dm_rsp,
    input wire pdm_rf_req_type rf_req,
    output pdm_rsp_type rf_rsp,
    input wire logic [3:0] bidir_port_a_in,
    input wire logic [3:0] bidir_port_b_in,
    input wire logic [3:0] bidir_port_c_in,
    input wire logic [3:0] group_bidir_port_in,
    output pdm_pin_drive_type bidir_port_a_drv,
    output pdm_pin_drive_type bidir_port_b_drv,
    output pdm_pin_drive_type bidir_port_c_drv,
    output pdm_pin_drive_type group_bidir_port_drv,
    output logic [3:0] segment_shared_out_port_e,
    output logic [3:0] segment_shared_out_port_f
);

    localparam int NPORT = 6;
    localparam int IW = $clog2(NPORT);
    // Store index order: a, b, group, c, segment e, segment f
    localparam logic [IW-1:0] IX_A = 3'd0;
    localparam logic [IW-1:0] IX_B = 3'd1;
    localparam logic [IW-1:0] IX_G = 3'd2;
    localparam logic [IW-1:0] IX_C = 3'd3;
    localparam logic [IW-1:0] IX_E = 3'd4;
    localparam logic [IW-1:0] IX_F = 3'd5;

    typedef struct packed {
        pdm_nib_type dir_a;
        pdm_nib_type dir_b;
        pdm_nib_type dir_c;
        logic dir_g;
        pdm_rsp_type dm_rsp;
        pdm_rsp_type rf_rsp;
        pdm_sel_type rd_sel;
        pdm_nib_type rd_in;
        pdm_nib_type rd_dir;
    } pdm_state_type;

    pdm_state_type s_q;
    pdm_state_type s_d;

    logic st_wr;
    logic [IW-1:0] st_idx;
    logic dm_hit;
    logic [3:0] st_rd;
    logic [NPORT*4-1:0] st_all;
    pdm_sel_type dm_sel;
    pdm_nib_type dm_pins;
    pdm_nib_type dir_now;
    pdm_nib_type gdir;

    // Data-memory decode; unallocated holes never hit, so writes are dropped
    always_comb begin
        dm_hit = 1'b1;
        st_idx = IX_A;
        dm_sel = PDM_SEL_NONE;
        dm_pins = 4'h0;
        dir_now = 4'h0;
        case (dm_req.bank)
            `PDM_BANK0: begin
                if (dm_req.addr == `PDM_DM_PORT_A) begin
                    st_idx = IX_A;
                    dm_sel = PDM_SEL_A;
                end else if (dm_req.addr == `PDM_DM_PORT_B) begin
                    st_idx = IX_B;
                    dm_sel = PDM_SEL_B;
                end else if (dm_req.addr == `PDM_DM_PORT_G) begin
                    st_idx = IX_G;
                    dm_sel = PDM_SEL_G;
                end else if (dm_req.addr == `PDM_DM_SEG_E) begin
                    st_idx = IX_E;
                end else if (dm_req.addr == `PDM_DM_SEG_F) begin
                    st_idx = IX_F;
                end else begin
                    dm_hit = 1'b0;
                end
            end
            `PDM_BANK1: begin
                if (dm_req.addr == `PDM_DM_PORT_C) begin
                    st_idx = IX_C;
                    dm_sel = PDM_SEL_C;
                end else begin
                    dm_hit = 1'b0;
                end
            end
            // no storage in these banks at port addresses
            `PDM_BANK2: dm_hit = 1'b0;
            `PDM_BANK3: dm_hit = 1'b0;
            default: dm_hit = 1'b0;
        endcase
        case (dm_sel)
            PDM_SEL_A: begin
                dm_pins = bidir_port_a_in;
                dir_now = s_q.dir_a;
            end
            PDM_SEL_B: begin
                dm_pins = bidir_port_b_in;
                dir_now = s_q.dir_b;
            end
            PDM_SEL_C: begin
                dm_pins = bidir_port_c_in;
                dir_now = s_q.dir_c;
            end
            PDM_SEL_G: begin
                dm_pins = group_bidir_port_in;
                dir_now = gdir;
            end
            default: begin
                dm_pins = 4'h0;
                dir_now = 4'hf;
            end
        endcase
    end

    assign gdir = {4{s_q.dir_g}};
    assign st_wr = dm_req.wr && dm_hit;

    pdm_nibble_store #(
        .DEPTH(NPORT)
    ) u_store (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_en(st_wr),
        .wr_idx(st_idx),
        .wr_data(dm_req.wdata),
        .rd_idx(st_idx),
        .rd_data(st_rd),
        .all_q(st_all)
    );

    always_comb begin
        s_d = s_q;
        s_d.dm_rsp = '0;
        s_d.rf_rsp = '0;
        s_d.rd_sel = PDM_SEL_NONE;
        s_d.rd_in = 4'h0;
        s_d.rd_dir = 4'h0;
        if (rf_req.wr) begin
            case (rf_req.addr)
                `PDM_RF_DIR_A: s_d.dir_a = rf_req.wdata;
                `PDM_RF_DIR_B: s_d.dir_b = rf_req.wdata;
                `PDM_RF_DIR_C: s_d.dir_c = rf_req.wdata;
                `PDM_RF_DIR_G: s_d.dir_g = rf_req.wdata[`PDM_GROUP_DIR_BIT];
                default: s_d.dir_g = s_q.dir_g;
            endcase
        end
        if (rf_req.rd) begin
            s_d.rf_rsp.hit = 1'b1;
            case (rf_req.addr)
                `PDM_RF_DIR_A: s_d.rf_rsp.rdata = s_q.dir_a;
                `PDM_RF_DIR_B: s_d.rf_rsp.rdata = s_q.dir_b;
                `PDM_RF_DIR_C: s_d.rf_rsp.rdata = s_q.dir_c;
                `PDM_RF_DIR_G: s_d.rf_rsp.rdata = {3'h0, s_q.dir_g};
                default: s_d.rf_rsp = '0;
            endcase
        end
        if (dm_req.rd && dm_hit) begin
            // Pins in input mode read the pad, output pins read the latch
            s_d.dm_rsp.hit = 1'b1;
            s_d.rd_sel = dm_sel;
            s_d.rd_dir = dir_now;
            s_d.rd_in = (dm_pins & ~dir_now);
        end
        if (dm_req.rd && !dm_hit && !(dm_req.bank == `PDM_BANK3 && !HAS_BANK3)) begin
            s_d.dm_rsp.hit = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q.dir_a <= `PDM_DIR_RESET;
            s_q.dir_b <= `PDM_DIR_RESET;
            s_q.dir_c <= `PDM_DIR_RESET;
            s_q.dir_g <= 1'b0;
            s_q.dm_rsp <= '0;
            s_q.rf_rsp <= '0;
            s_q.rd_sel <= PDM_SEL_NONE;
            s_q.rd_in <= 4'h0;
            s_q.rd_dir <= 4'h0;
        end else begin
            s_q <= s_d;
        end
    end

    // Latched part masked by the direction seen with the request, so a
    // direction write in the same cycle cannot mix old and new settings
    always_comb begin
        dm_rsp.hit = s_q.dm_rsp.hit;
        case (s_q.rd_sel)
            PDM_SEL_A: dm_rsp.rdata = (st_rd & s_q.rd_dir) | s_q.rd_in;
            PDM_SEL_B: dm_rsp.rdata = (st_rd & s_q.rd_dir) | s_q.rd_in;
            PDM_SEL_C: dm_rsp.rdata = (st_rd & s_q.rd_dir) | s_q.rd_in;
            PDM_SEL_G: dm_rsp.rdata = (st_rd & s_q.rd_dir) | s_q.rd_in;
            default: dm_rsp.rdata = s_q.dm_rsp.hit ? st_rd : 4'h0;
        endcase
    end

    assign rf_rsp = s_q.rf_rsp;
    assign bidir_port_a_drv = '{out: st_all[IX_A*4 +: 4], oe: s_q.dir_a};
    assign bidir_port_b_drv = '{out: st_all[IX_B*4 +: 4], oe: s_q.dir_b};
    assign bidir_port_c_drv = '{out: st_all[IX_C*4 +: 4], oe: s_q.dir_c};
    assign group_bidir_port_drv = '{out: st_all[IX_G*4 +: 4], oe: gdir};
    assign segment_shared_out_port_e = st_all[IX_E*4 +: 4];
    assign segment_shared_out_port_f = st_all[IX_F*4 +: 4];

endmodule : pdm_port_map

/* testbench/pdm_port_map_monitor.sv */
/* Concurrent checks on the port map.
   Assumes it is bound into pdm_port_map and everything runs on clk_sys. */
module pdm_port_map_monitor
    import pdm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire pdm_dm_req_type dm_req,
    input wire pdm_rsp_type dm_rsp,
    input wire pdm_rf_req_type rf_req,
    input wire pdm_rsp_type rf_rsp,
    input wire logic [3:0] bidir_port_a_in,
    input wire pdm_pin_drive_type bidir_port_a_drv,
    input wire pdm_pin_drive_type group_bidir_port_drv
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_rf_wr(a);
        rf_req.wr && rf_req.addr == a;
    endsequence
    sequence s_dm_rd_a;
        dm_req.rd && dm_req.bank == 2'h0 && dm_req.addr == 7'h70;
    endsequence
    a_dir_a_load: assert property (s_rf_wr(7'h37) |=> bidir_port_a_drv.oe == $past(rf_req.wdata))
        else $error("port a direction not loaded");
    a_dir_a_keep: assert property (!(rf_req.wr && rf_req.addr == 7'h37) |=> $stable(bidir_port_a_drv.oe))
        else $error("port a direction moved");
    a_group_whole: assert property (group_bidir_port_drv.oe inside {4'h0, 4'hf})
        else $error("group pins split");
    a_group_load: assert property (s_rf_wr(7'h27) |=> group_bidir_port_drv.oe == {4{$past(rf_req.wdata[0])}})
        else $error("group direction not loaded");
    a_group_read: assert property (rf_req.rd && rf_req.addr == 7'h27 |=> rf_rsp.hit && rf_rsp.rdata == {3'h0, $past(group_bidir_port_drv.oe[0])})
        else $error("group direction read wrong");
    a_data_drive: assert property (dm_req.wr && dm_req.bank == 2'h0 && dm_req.addr == 7'h70 |=> bidir_port_a_drv.out == $past(dm_req.wdata))
        else $error("port a latch not loaded");
    a_read_mix: assert property (s_dm_rd_a |=> dm_rsp.hit && dm_rsp.rdata == (($past(bidir_port_a_drv.out) & $past(bidir_port_a_drv.oe)) | ($past(bidir_port_a_in) & ~$past(bidir_port_a_drv.oe))))
        else $error("port a read wrong");
    a_hole_empty: assert property (dm_req.rd && (dm_req.bank == 2'h3 || (dm_req.bank == 2'h2 && dm_req.addr inside {[7'h71:7'h73]})) |=> !dm_rsp.hit && dm_rsp.rdata == 4'h0)
        else $error("hole answered");
    a_reset_input: assert property (disable iff (1'b0) rst |=> bidir_port_a_drv.oe == 4'h0 && group_bidir_port_drv.oe == 4'h0)
        else $error("direction not cleared");
endmodule : pdm_port_map_monitor

bind pdm_port_map pdm_port_map_monitor pdm_port_map_monitor_i (.clk_sys(clk_sys), .rst(rst),
    .dm_req(dm_req), .dm_rsp(dm_rsp), .rf_req(rf_req), .rf_rsp(rf_rsp),
    .bidir_port_a_in(bidir_port_a_in), .bidir_port_a_drv(bidir_port_a_drv),
    .group_bidir_port_drv(group_bidir_port_drv));

/* testbench/pdm_pin_board.sv */
/* Board model of one 4-pin bidirectional port.
   Assumes the bench gives the level each released pin is pulled to. */
module pdm_pin_board
    import pdm_pkg::*;
(
    input wire pdm_pin_drive_type drv,
    input wire logic [3:0] ext,
    output logic [3:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pin carries the latch, a released one the board level
    assign pin = (drv.out & drv.oe) | (ext & ~drv.oe);
endmodule : pdm_pin_board

/* testbench/pdm_port_map_tb.sv */
/* Self-checking bench of the port map.
   Assumes pdm_pkg, the pin board model and the bound monitor are compiled. */
module pdm_port_map_tb
    import pdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0] dir;
        logic [3:0] data;
        logic [3:0] pin;
        logic [3:0] exp;
    } pdm_row_type;
    pdm_row_type rows [4] = '{'{4'h0, 4'ha, 4'h5, 4'h5}, '{4'hf, 4'ha, 4'h5, 4'ha},
        '{4'h9, 4'h6, 4'h3, 4'h2}, '{4'h6, 4'hc, 4'h9, 4'hd}};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    pdm_dm_req_type dm_req = '0;
    pdm_rf_req_type rf_req = '0;
    pdm_rsp_type dm_rsp, rf_rsp, rsp;
    pdm_pin_drive_type a_drv, b_drv, c_drv, g_drv;
    logic [3:0] a_in, b_in, c_in, g_in, seg_e, seg_f;
    logic [15:0] ext = 16'h3c96;
    int n_fail = 0;
    int n_compared = 0;
    always #20 clk_sys = ~clk_sys;
    pdm_port_map pdm_port_map_i (.clk_sys(clk_sys), .rst(rst), .dm_req(dm_req),
        .dm_rsp(dm_rsp), .rf_req(rf_req), .rf_rsp(rf_rsp), .bidir_port_a_in(a_in),
        .bidir_port_b_in(b_in), .bidir_port_c_in(c_in), .group_bidir_port_in(g_in),
        .bidir_port_a_drv(a_drv), .bidir_port_b_drv(b_drv), .bidir_port_c_drv(c_drv),
        .group_bidir_port_drv(g_drv), .segment_shared_out_port_e(seg_e),
        .segment_shared_out_port_f(seg_f));
    pdm_pin_board pdm_pin_board_a_i (.drv(a_drv), .ext(ext[3:0]), .pin(a_in));
    pdm_pin_board pdm_pin_board_b_i (.drv(b_drv), .ext(ext[7:4]), .pin(b_in));
    pdm_pin_board pdm_pin_board_c_i (.drv(c_drv), .ext(ext[11:8]), .pin(c_in));
    pdm_pin_board pdm_pin_board_g_i (.drv(g_drv), .ext(ext[15:12]), .pin(g_in));
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic dm(input logic [1:0] bank, input logic [6:0] addr, input logic wr,
        input logic [3:0] wdata);
        @(negedge clk_sys);
        dm_req = '{bank, addr, wr, ~wr, wdata};
        @(negedge clk_sys);
        dm_req = '0;
        rsp = dm_rsp;
    endtask : dm
    task automatic rf(input logic [6:0] addr, input logic wr, input logic [3:0] wdata);
        @(negedge clk_sys);
        rf_req = '{addr, wr, ~wr, wdata};
        @(negedge clk_sys);
        rf_req = '0;
        rsp = rf_rsp;
    endtask : rf
    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        #80000;
        n_fail++;
        $display("watchdog expired");
        test_done();
    end
    initial begin
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        check("oe after reset", a_drv.oe | b_drv.oe | c_drv.oe | g_drv.oe, 4'h0);
        foreach (rows[i]) begin
            rf(7'h37, 1'b1, rows[i].dir);
            check("a dir", a_drv.oe, rows[i].dir);
            dm(2'h0, 7'h70, 1'b1, rows[i].data);
            ext[3:0] = rows[i].pin;
            check("a out", a_drv.out, rows[i].data);
            dm(2'h0, 7'h70, 1'b0, 4'h0);
            check("a read", rsp.rdata, rows[i].exp);
            check("a read hit", {3'h0, rsp.hit}, 4'h1);
            rf(7'h37, 1'b0, 4'h0);
            check("a dir read", rsp.rdata, rows[i].dir);
        end
        $display("table tests done");
        rf(7'h36, 1'b1, 4'h3);
        rf(7'h35, 1'b1, 4'hc);
        check("b dir", b_drv.oe, 4'h3);
        check("c dir", c_drv.oe, 4'hc);
        check("a dir kept", a_drv.oe, 4'h6);
        rf(7'h27, 1'b1, 4'he);
        check("group off", g_drv.oe, 4'h0);
        rf(7'h27, 1'b1, 4'h1);
        check("group on", g_drv.oe, 4'hf);
        rf(7'h27, 1'b0, 4'h0);
        check("group read", rsp.rdata, 4'h1);
        rf(7'h36, 1'b0, 4'h0);
        check("b dir read", rsp.rdata, 4'h3);
        ext[11:8] = 4'h3;
        dm(2'h1, 7'h70, 1'b1, 4'h5);
        check("c out", c_drv.out, 4'h5);
        dm(2'h1, 7'h70, 1'b0, 4'h0);
        check("c read", rsp.rdata, 4'h7);
        dm(2'h0, 7'h72, 1'b1, 4'ha);
        check("group out", g_drv.out, 4'ha);
        dm(2'h0, 7'h72, 1'b0, 4'h0);
        check("group read out", rsp.rdata, 4'ha);
        rf(7'h27, 1'b1, 4'h0);
        dm(2'h0, 7'h72, 1'b0, 4'h0);
        check("group read in", rsp.rdata, 4'h3);
        $display("direction tests done");
        dm(2'h0, 7'h71, 1'b1, 4'h5);
        // Bank 2 71H-73H first, then bank 3 70H-73H
        for (int k = 1; k < 8; k++) begin
            dm(k < 4 ? 2'h2 : 2'h3, {5'h1c, k[1:0]}, 1'b1, 4'hf);
            dm(k < 4 ? 2'h2 : 2'h3, {5'h1c, k[1:0]}, 1'b0, 4'h0);
            check("hole hit", {3'h0, rsp.hit}, 4'h0);
            check("hole data", rsp.rdata, 4'h0);
        end
        check("b latch kept", b_drv.out, 4'h5);
        dm(2'h0, 7'h71, 1'b0, 4'h0);
        check("b read", rsp.rdata, 4'h9);
        dm(2'h0, 7'h6b, 1'b1, 4'h9);
        dm(2'h0, 7'h6d, 1'b1, 4'h4);
        check("seg e", seg_e, 4'h9);
        check("seg f", seg_f, 4'h4);
        dm(2'h0, 7'h6b, 1'b0, 4'h0);
        check("seg e read", rsp.rdata, 4'h9);
        $display("memory map tests done");
        @(negedge clk_sys);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        check("oe after second reset", a_drv.oe | b_drv.oe | c_drv.oe | g_drv.oe, 4'h0);
        $display("reset tests done");
        test_done();
    end
endmodule : pdm_port_map_tb
